//--- mcc_master_config.sv
// How it works
// - master_config is a 16-bit host read-write register cleared by the master reset pin.
// - Monitor and terminal soft resets never touch master_config; only arst_n clears it.
// - Bit 15 ORed with the bus A inhibit pin blocks all bus A transmission while high.
// - Bit 14 ORed with the bus B inhibit pin blocks all bus B transmission while high.
// - With enable pin and bit both high, writing 1 to bit 13 and 1 to bit 12 launches an idle controller.
// - The launch bit self-clears after a write of 1 and always reads back 0.
// - Dropping the combined enable cancels a pending launch.
// - Bit 12 ANDed with the enable pin; either at 0 disables the controller.
// - A write of 1 to bit 12 is ignored while the enable pin is 0.
// - An enabled controller stays idle until the launch bit is written with 1.
// - If the enable drops while running, the current op code finishes, then it halts.
`default_nettype none

module mcc_master_config
    import mcc_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    input  wire logic                  host_wr_en,
    input  wire logic                  host_rd_en,
    input  wire logic [MCC_ADDR_W-1:0] host_addr,
    input  wire logic [MCC_DATA_W-1:0] host_wdata,
    output logic [MCC_DATA_W-1:0]      host_rdata,
    output logic                       host_rvalid,
    input  wire logic                  bus_a_transmit_inhibit,
    input  wire logic                  bus_b_transmit_inhibit,
    input  wire logic                  controller_enable,
    input  wire logic                  opcode_done,
    output logic                       bus_a_tx_blocked,
    output logic                       bus_b_tx_blocked,
    output logic                       controller_enabled,
    output logic                       controller_launch,
    output logic                       controller_running
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    mcc_pin_if #(.W(MCC_PIN_W)) pin_bus ();

    assign pin_bus.raw[MCC_PIN_INHIBIT_A] = bus_a_transmit_inhibit;
    assign pin_bus.raw[MCC_PIN_INHIBIT_B] = bus_b_transmit_inhibit;
    assign pin_bus.raw[MCC_PIN_ENABLE]    = controller_enable;

    mcc_pin_sync #(.W(MCC_PIN_W)) u_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .pins    (pin_bus.sync_side)
    );

    logic pin_inh_a;
    logic pin_inh_b;
    logic pin_en;

    assign pin_inh_a = pin_bus.sync[MCC_PIN_INHIBIT_A];
    assign pin_inh_b = pin_bus.sync[MCC_PIN_INHIBIT_B];
    assign pin_en    = pin_bus.sync[MCC_PIN_ENABLE];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [MCC_DATA_W-1:0] cfg;
        mcc_state_t            state;
        logic [MCC_DATA_W-1:0] rdata;
        logic                  rvalid;
        logic                  blk_a;
        logic                  blk_b;
        logic                  en;
        logic                  launch;
        logic                  running;
    } mcc_top_state_t;

    mcc_top_state_t s_q;
    mcc_top_state_t s_d;

    logic cfg_wr;
    logic cfg_rd;
    logic en_now;
    logic start_wr;

    assign cfg_wr   = host_wr_en && (host_addr == MCC_MASTER_CONFIG);
    assign cfg_rd   = host_rd_en && (host_addr == MCC_MASTER_CONFIG);
    // Launch qualifies against the enable in force before this write lands
    assign en_now   = s_q.cfg[MCC_BIT_ENABLE] && pin_en;
    assign start_wr = cfg_wr && host_wdata[MCC_BIT_LAUNCH];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        s_d.launch = 1'b0;

        // Only arst_n clears the register; soft resets are not inputs here
        if (cfg_wr) begin
            s_d.cfg                 = host_wdata;
            s_d.cfg[MCC_BIT_LAUNCH] = 1'b0;
            s_d.cfg[MCC_BIT_ENABLE] = host_wdata[MCC_BIT_ENABLE] && pin_en;
        end

        if (host_rd_en) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = cfg_rd ? s_q.cfg : MCC_RD_UNMAPPED;
        end

        case (s_q.state)
            MCC_ST_IDLE: begin
                if (start_wr && en_now) begin
                    s_d.state = MCC_ST_ARMED;
                end
            end
            MCC_ST_ARMED: begin
                if (!en_now) begin
                    s_d.state = MCC_ST_IDLE;
                end else begin
                    s_d.launch = 1'b1;
                    s_d.state  = MCC_ST_RUN;
                end
            end
            MCC_ST_RUN: begin
                if (!en_now) begin
                    s_d.state = opcode_done ? MCC_ST_IDLE : MCC_ST_STOP;
                end
            end
            MCC_ST_STOP: begin
                if (opcode_done) begin
                    s_d.state = MCC_ST_IDLE;
                end
            end
            default: begin
                s_d.state = MCC_ST_IDLE;
            end
        endcase

        s_d.running = (s_d.state == MCC_ST_RUN) || (s_d.state == MCC_ST_STOP);
        s_d.en      = s_d.cfg[MCC_BIT_ENABLE] && pin_en;
        s_d.blk_a   = s_d.cfg[MCC_BIT_INHIBIT_A] || pin_inh_a;
        s_d.blk_b   = s_d.cfg[MCC_BIT_INHIBIT_B] || pin_inh_b;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q         <= '0;
            s_q.cfg     <= MCC_CFG_RESET;
            s_q.rdata   <= MCC_RD_UNMAPPED;
            s_q.state   <= MCC_ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign host_rdata         = s_q.rdata;
    assign host_rvalid        = s_q.rvalid;
    assign bus_a_tx_blocked   = s_q.blk_a;
    assign bus_b_tx_blocked   = s_q.blk_b;
    assign controller_enabled = s_q.en;
    assign controller_launch  = s_q.launch;
    assign controller_running = s_q.running;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_launch_reads_zero;
        s_q.rvalid |-> !host_rdata[MCC_BIT_LAUNCH];
    endproperty
    a_launch_reads_zero: assert property (p_launch_reads_zero)
        else $error("launch bit read back as one");

    property p_cfg_write;
        (cfg_wr && !host_wdata[MCC_BIT_LAUNCH]) |=>
            s_q.cfg[MCC_BIT_INHIBIT_A:MCC_BIT_INHIBIT_B]
                == $past(host_wdata[MCC_BIT_INHIBIT_A:MCC_BIT_INHIBIT_B]);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("master_config write not stored");

    property p_inhibit_a;
        // A write that clears bit 15 in this cycle takes the cause away
        (pin_inh_a || (s_q.cfg[MCC_BIT_INHIBIT_A] && !cfg_wr)
            || (cfg_wr && host_wdata[MCC_BIT_INHIBIT_A])) |=> bus_a_tx_blocked;
    endproperty
    a_inhibit_a: assert property (p_inhibit_a)
        else $error("bus A not blocked");

    property p_inhibit_b;
        (!pin_inh_b && !s_q.cfg[MCC_BIT_INHIBIT_B] && !cfg_wr) |=> !bus_b_tx_blocked;
    endproperty
    a_inhibit_b: assert property (p_inhibit_b)
        else $error("bus B blocked with no cause");

    property p_launch;
        (s_q.state == MCC_ST_IDLE && start_wr && en_now && pin_en) |=>
            (s_q.state == MCC_ST_ARMED) ##1 (controller_launch || !$past(en_now));
    endproperty
    a_launch: assert property (p_launch)
        else $error("launch did not follow start write");

    property p_cancel;
        (s_q.state == MCC_ST_ARMED && !en_now) |=> !controller_launch && !controller_running;
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("pending launch not cancelled");

    property p_enable_blocked;
        (cfg_wr && !pin_en) |=> !s_q.cfg[MCC_BIT_ENABLE] && !controller_enabled;
    endproperty
    a_enable_blocked: assert property (p_enable_blocked)
        else $error("enable bit set with pin low");

    property p_idle_hold;
        (s_q.state == MCC_ST_IDLE && !start_wr) |=> !controller_running ##1 !controller_launch;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("controller left idle without start");

    property p_halt;
        (s_q.state == MCC_ST_STOP && !opcode_done) |=> controller_running;
    endproperty
    a_halt: assert property (p_halt)
        else $error("stopped before op code finished");

    property p_disable;
        (!en_now && !cfg_wr) |=> !controller_enabled;
    endproperty
    a_disable: assert property (p_disable)
        else $error("controller enabled with pin or bit low");

    c_launch: cover property (controller_launch);
    c_halt:   cover property (s_q.state == MCC_ST_STOP ##1 s_q.state == MCC_ST_IDLE);
    c_cancel: cover property (s_q.state == MCC_ST_ARMED && !en_now);

endmodule

`default_nettype wire

//--- mcc_pkg.sv
`default_nettype none

package mcc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          MCC_ADDR_W        = 16;
    localparam int          MCC_DATA_W        = 16;
    localparam logic [15:0] MCC_MASTER_CONFIG = 16'h0000;
    localparam logic [15:0] MCC_CFG_RESET     = 16'h0000;
    localparam logic [15:0] MCC_RD_UNMAPPED   = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions of master_config
    // ------------------------------------------------------------------
    localparam int MCC_BIT_INHIBIT_A = 15;
    localparam int MCC_BIT_INHIBIT_B = 14;
    localparam int MCC_BIT_LAUNCH    = 13;
    localparam int MCC_BIT_ENABLE    = 12;

    // ------------------------------------------------------------------
    // Pin synchroniser lanes
    // ------------------------------------------------------------------
    localparam int MCC_PIN_W        = 3;
    localparam int MCC_PIN_INHIBIT_A = 0;
    localparam int MCC_PIN_INHIBIT_B = 1;
    localparam int MCC_PIN_ENABLE   = 2;

    // ------------------------------------------------------------------
    // Controller sequencing
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        MCC_ST_IDLE  = 4'b0001,
        MCC_ST_ARMED = 4'b0010,
        MCC_ST_RUN   = 4'b0100,
        MCC_ST_STOP  = 4'b1000
    } mcc_state_t;

endpackage

`default_nettype wire

//--- mcc_pin_if.sv
`default_nettype none

interface mcc_pin_if #(
    parameter int W = 3
);
    logic [W-1:0] raw;
    logic [W-1:0] sync;

    modport sync_side (
        input  raw,
        output sync
    );
    modport user (
        output raw,
        input  sync
    );
endinterface

`default_nettype wire

//--- mcc_pin_sync.sv
`default_nettype none

module mcc_pin_sync #(
    parameter int W = 3
) (
    input  wire logic    ref_clk,
    input  wire logic    arst_n,
    mcc_pin_if.sync_side pins
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } mcc_sync_state_t;

    mcc_sync_state_t s_q;
    mcc_sync_state_t s_d;

    // First stage feeds only the second stage
    always_comb begin
        s_d.first  = pins.raw;
        s_d.second = s_q.first;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins.sync = s_q.second;

endmodule

`default_nettype wire

//--- mcc_host_model.sv
`default_nettype none

module mcc_host_model
    import mcc_pkg::*;
(
    input  wire logic                  ref_clk,
    output logic                       host_wr_en,
    output logic                       host_rd_en,
    output logic [MCC_ADDR_W-1:0]      host_addr,
    output logic [MCC_DATA_W-1:0]      host_wdata,
    input  wire logic [MCC_DATA_W-1:0] host_rdata,
    input  wire logic                  host_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Host port cycles
    // ------------------------------------------------------------------
    // Called once at time zero so the bench process is the only driver
    task automatic init();
        host_wr_en = 1'b0;
        host_rd_en = 1'b0;
        host_addr  = 16'hffff;
        host_wdata = 16'h0000;
    endtask

    // Data is inverted once released so a stale value cannot pass by luck
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        host_wr_en <= 1'b1;
        host_addr  <= a;
        host_wdata <= d;
        @(posedge ref_clk);
        host_wr_en <= 1'b0;
        host_wdata <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
        @(posedge ref_clk);
        host_rd_en <= 1'b1;
        host_addr  <= a;
        @(posedge ref_clk);
        host_rd_en <= 1'b0;
        #1;
        v = host_rvalid;
        d = host_rdata;
    endtask
endmodule

`default_nettype wire

//--- master_configuration_control_tb.sv
`default_nettype none

module master_configuration_control_tb
    import mcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk;
    logic        arst_n;
    logic        wr_en;
    logic        rd_en;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        rvalid;
    logic        pin_a;
    logic        pin_b;
    logic        pin_en;
    logic        op_done;
    logic        blk_a;
    logic        blk_b;
    logic        en_q;
    logic        launch;
    logic        running;
    logic [15:0] rv;
    logic        vv;
    int          err_count;
    int          n_tests;
    int          hits;

    mcc_master_config i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .host_wr_en(wr_en), .host_rd_en(rd_en),
        .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata), .host_rvalid(rvalid),
        .bus_a_transmit_inhibit(pin_a), .bus_b_transmit_inhibit(pin_b),
        .controller_enable(pin_en), .opcode_done(op_done), .bus_a_tx_blocked(blk_a),
        .bus_b_tx_blocked(blk_b), .controller_enabled(en_q),
        .controller_launch(launch), .controller_running(running)
    );

    mcc_host_model i_host (
        .ref_clk(ref_clk), .host_wr_en(wr_en), .host_rd_en(rd_en), .host_addr(addr),
        .host_wdata(wdata), .host_rdata(rdata), .host_rvalid(rvalid)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic read_cfg(input logic [15:0] exp);
        i_host.rd(MCC_MASTER_CONFIG, rv, vv);
        check({15'h0, vv}, 16'h0001);
        check(rv, exp);
    endtask

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, reset and watchdog
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        #100us;
        err_count++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        i_host.init();
        arst_n = 1'b0;
        pin_a = 1'b0;
        pin_b = 1'b0;
        pin_en = 1'b0;
        op_done = 1'b0;
        err_count = 0;
        n_tests = 0;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        tick(1);
        check({11'h0, blk_a, blk_b, en_q, launch, running}, 16'h0000);
        read_cfg(MCC_CFG_RESET);
        $display("test reset done");

        // Enable bit refused with the pin low; launch bit never reads back
        i_host.wr(MCC_MASTER_CONFIG, 16'hffff);
        tick(3);
        check({15'h0, en_q}, 16'h0000);
        check({15'h0, launch | running}, 16'h0000);
        read_cfg(16'hcfff);
        read_cfg(16'hcfff);
        $display("test refused bits done");

        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            pin_a <= i[1];
            pin_b <= i[0];
            i_host.wr(MCC_MASTER_CONFIG, {i[3], i[2], 14'h0});
            tick(3);
            check({15'h0, blk_a}, {15'h0, i[3] | i[1]});
            check({15'h0, blk_b}, {15'h0, i[2] | i[0]});
        end
        $display("test inhibit table done");

        @(posedge ref_clk);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
        pin_en <= 1'b1;
        tick(3);
        i_host.wr(MCC_MASTER_CONFIG, 16'h1000);
        i_host.wr(16'h0004, 16'hffff);
        i_host.rd(16'h0004, rv, vv);
        check(rv, MCC_RD_UNMAPPED);
        tick(2);
        check({15'h0, en_q}, 16'h0001);
        tick(8);
        check({14'h0, launch, running}, 16'h0000);
        read_cfg(16'h1000);
        $display("test enable done");

        // Configuration is written first, then launched
        i_host.wr(MCC_MASTER_CONFIG, 16'h3000);
        hits = 0;
        for (int k = 0; k < 6; k++) begin
            tick(1);
            hits += launch;
        end
        check(16'(hits), 16'h0001);
        check({15'h0, running}, 16'h0001);
        read_cfg(16'h1000);
        $display("test launch done");

        // Op code in flight must finish before the halt
        @(posedge ref_clk);
        pin_en <= 1'b0;
        tick(6);
        check({14'h0, en_q, running}, 16'h0001);
        @(posedge ref_clk);
        op_done <= 1'b1;
        @(posedge ref_clk);
        op_done <= 1'b0;
        tick(2);
        check({14'h0, launch, running}, 16'h0000);
        hits = 0;
        for (int k = 0; k < 8; k++) begin
            tick(1);
            hits += launch;
        end
        check(16'(hits), 16'h0000);
        $display("test halt done");

        // Start accepted on the old enable, then cancelled as the bit drops
        @(posedge ref_clk);
        pin_en <= 1'b1;
        tick(3);
        i_host.wr(MCC_MASTER_CONFIG, 16'h1000);
        i_host.wr(MCC_MASTER_CONFIG, 16'h2000);
        hits = 0;
        for (int k = 0; k < 8; k++) begin
            tick(1);
            hits += launch;
        end
        check(16'(hits), 16'h0000);
        check({15'h0, running}, 16'h0000);
        read_cfg(16'h0000);
        $display("test cancel done");

        // Reset with bits 15, 14 and 12 set, controller idle, clears every bit
        i_host.wr(MCC_MASTER_CONFIG, 16'hd000);
        tick(2);
        check({13'h0, blk_a, blk_b, en_q}, 16'h0007);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        @(posedge ref_clk);
        arst_n <= 1'b1;
        tick(1);
        check({11'h0, blk_a, blk_b, en_q, launch, running}, 16'h0000);
        read_cfg(MCC_CFG_RESET);
        $display("test mid reset done");
        finish_test();
    end
endmodule

`default_nettype wire
